// File: design/adcrc_regs.sv
// Result, offset and full-scale registers of a delta-sigma converter.
// Assumes the filter, the serial front end and the command register run on CLK_I.
//
// Notes on behaviour
// - latest result kept in 24 bits, byte 2 most significant, byte 0 least
// - new result loaded into the register just before ready goes low
// - unread result is overwritten by the next one after one data period
// - ready forced high before update, but not while a result read runs
// - result coded two's complement or offset binary by the format select
// - unipolar select limits results to non-negative values
// - 24-bit offset correction applied to each result before storing
// - host may read and write the offset correction register
// - calibration sequences load offset and full-scale registers
// - offset correction is a linear function of the stored offset
// - offset register always read as two's complement
// - 24-bit full-scale correction applied to each result before storing
// - host may read and write the full-scale correction register
// - full-scale correction is a linear function of the stored value
// - full-scale register always treated as unsigned binary
// - read-only status bit mirrors ready: 0 ready, 1 not ready
// - mode codes 001, 010, 011 start calibrations, then return to normal
module adcrc_regs
    import adcrc_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // conversions from the digital filter
    input wire logic RAW_VALID_I,
    input wire logic [DW-1:0] RAW_DATA_I,
    // command register fields
    input wire logic FORMAT_SEL_I,
    input wire logic UNIPOLAR_I,
    input wire logic MODE_WR_I,
    input wire logic [2:0] MODE_I,
    // host register writes
    input wire logic WR_I,
    input wire adcrc_wr_t WR_REQ_I,
    // host register reads
    input wire logic RD_REQ_I,
    input wire logic [1:0] RD_SEL_I,
    input wire logic RD_ACK_I,
    output adcrc_rdbyte_t RD_BYTE_O,
    // status
    output logic RESULT_READY_N_O,
    output logic [2:0] OPERATING_MODE_SEL_O,
    output logic CAL_DONE_O
);
    // ===========================================================
    // correction and coding
    function automatic logic [DW-1:0] correct(input logic [DW-1:0] raw,
            input logic [DW-1:0] off, input logic [DW-1:0] fs,
            input logic fmt, input logic uni);
        logic signed [25:0] diff;
        logic signed [50:0] prod;
        logic signed [50:0] sc;
        logic [DW-1:0] r;
        // offset register is signed, full-scale unsigned, whatever the format
        diff = 26'(signed'(raw)) - (26'(signed'(off)) <<< OFF_SHIFT);
        prod = 51'(diff) * 51'(signed'({1'b0, fs}));
        sc = prod >>> FS_SHIFT;
        if (sc > 51'(POS_MAX)) begin
            r = POS_MAX;
        end else if (sc < 51'(NEG_MIN)) begin
            r = NEG_MIN;
        end else begin
            r = sc[DW-1:0];
        end
        if (uni && r[DW-1]) begin
            r = '0;
        end
        if (fmt) begin
            r = r ^ SIGN_FLIP;
        end
        return r;
    endfunction

    // full-scale estimate from a measured span: first-order reciprocal
    function automatic logic [DW-1:0] fs_from_span(input logic [DW-1:0] raw,
            input logic [DW-1:0] off);
        logic [24:0] span;
        span = 25'(raw) - (25'(off) << OFF_SHIFT);
        return DW'(FSCALE_TWICE - span);
    endfunction

    // ===========================================================
    // state
    logic [DW-1:0] result;
    logic [DW-1:0] offset_corr;
    logic [DW-1:0] fscale_corr;
    logic [DW-1:0] pend;
    logic [DW-1:0] snap;
    logic [1:0] rd_idx;
    logic [1:0] rd_sel;
    logic [2:0] mode;
    logic self_stage;
    logic result_ready_n_n;
    logic cal_done;
    adcrc_upd_t upd;
    adcrc_rdbyte_t rd_byte;

    wire logic in_cal = (mode == MODE_SELF_CAL) || (mode == MODE_SYS_OFFSET)
        || (mode == MODE_SYS_FSCALE);
    wire logic rd_start = RD_REQ_I && !rd_byte.valid;
    wire logic rd_last = rd_byte.valid && RD_ACK_I && (rd_idx == IDX_BYTE0);
    wire logic reading_result = rd_byte.valid && (rd_sel == SEL_RESULT);
    wire logic conv_take = RAW_VALID_I && !in_cal && (upd == UPD_IDLE)
        && !reading_result;
    wire logic cal_off_step = RAW_VALID_I && ((mode == MODE_SYS_OFFSET)
        || (mode == MODE_SELF_CAL && !self_stage));
    wire logic cal_fs_step = RAW_VALID_I && ((mode == MODE_SYS_FSCALE)
        || (mode == MODE_SELF_CAL && self_stage));

    // ===========================================================
    // result update sequence
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            upd <= UPD_IDLE;
            pend <= '0;
        end else begin
            case (upd)
                UPD_IDLE: begin
                    // a result arriving during a result read is dropped
                    if (conv_take) begin
                        pend <= correct(RAW_DATA_I, offset_corr, fscale_corr,
                            FORMAT_SEL_I, UNIPOLAR_I);
                        upd <= UPD_LOAD;
                    end
                end
                UPD_LOAD: upd <= UPD_SHOW;
                UPD_SHOW: upd <= UPD_IDLE;
                default: upd <= UPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            result <= '0;
        end else if (upd == UPD_LOAD) begin
            result <= pend;
        end
    end

    // ready: high before load, low the cycle after, high again once read
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            result_ready_n_n <= 1'b1;
        end else if (conv_take) begin
            result_ready_n_n <= 1'b1;
        end else if (upd == UPD_SHOW) begin
            result_ready_n_n <= 1'b0;
        end else if (rd_last && rd_sel == SEL_RESULT) begin
            result_ready_n_n <= 1'b1;
        end
    end

    // ===========================================================
    // operating mode and calibration
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mode <= MODE_NORMAL;
            self_stage <= 1'b0;
            cal_done <= 1'b0;
        end else begin
            cal_done <= 1'b0;
            if (in_cal && (cal_fs_step || (cal_off_step
                    && mode == MODE_SYS_OFFSET))) begin
                mode <= MODE_NORMAL;
                self_stage <= 1'b0;
                cal_done <= 1'b1;
            end else if (cal_off_step && mode == MODE_SELF_CAL) begin
                self_stage <= 1'b1;
            end else if (MODE_WR_I) begin
                mode <= MODE_I;
                self_stage <= 1'b0;
            end
        end
    end

    // calibration beats a host write landing in the same cycle
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            offset_corr <= OFFSET_RST;
        end else if (cal_off_step) begin
            // inverse of the doubled offset term, arithmetic shift keeps sign
            offset_corr <= DW'(signed'(RAW_DATA_I) >>> OFF_SHIFT);
        end else if (WR_I && WR_REQ_I.sel == SEL_OFFSET) begin
            offset_corr <= WR_REQ_I.data;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fscale_corr <= FSCALE_RST;
        end else if (cal_fs_step) begin
            fscale_corr <= fs_from_span(RAW_DATA_I, offset_corr);
        end else if (WR_I && WR_REQ_I.sel == SEL_FSCALE) begin
            fscale_corr <= WR_REQ_I.data;
        end
    end

    // ===========================================================
    // host reads, most significant byte first
    function automatic logic [DW-1:0] reg_mux(input logic [1:0] sel);
        logic [DW-1:0] v;
        v = '0;
        case (sel)
            SEL_RESULT: v = result;
            SEL_OFFSET: v = offset_corr;
            SEL_FSCALE: v = fscale_corr;
            SEL_STATUS: v[STAT_READY_BIT] = result_ready_n_n;
            default: v = '0;
        endcase
        return v;
    endfunction

    function automatic logic [BW-1:0] pick(input logic [DW-1:0] v,
            input logic [1:0] idx);
        return v[idx*BW +: BW];
    endfunction

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            snap <= '0;
            rd_idx <= IDX_BYTE2;
            rd_sel <= SEL_RESULT;
            rd_byte <= '0;
        end else if (rd_start) begin
            snap <= reg_mux(RD_SEL_I);
            rd_sel <= RD_SEL_I;
            rd_idx <= IDX_BYTE2;
            rd_byte.valid <= 1'b1;
            rd_byte.data <= pick(reg_mux(RD_SEL_I), IDX_BYTE2);
        end else if (rd_last) begin
            rd_byte <= '0;
        end else if (rd_byte.valid && RD_ACK_I) begin
            rd_idx <= rd_idx - 2'h1;
            rd_byte.data <= pick(snap, rd_idx - 2'h1);
        end
    end

    // ===========================================================
    // outputs
    always_comb RD_BYTE_O = rd_byte;
    always_comb RESULT_READY_N_O = result_ready_n_n;
    always_comb OPERATING_MODE_SEL_O = mode;
    always_comb CAL_DONE_O = cal_done;

    // ===========================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence load_then_low;
        (upd == UPD_LOAD && result_ready_n_n) ##1 (result == $past(pend)) ##1 !result_ready_n_n;
    endsequence

    sequence bytes_out(logic [DW-1:0] v);
        rd_byte.valid && rd_byte.data == v[23:16] && snap == v;
    endsequence
    sequence next_byte;
        rd_byte.valid && rd_byte.data == snap[15:8];
    endsequence

    load_order_a: assert property (conv_take |=> load_then_low)
        else $error("result not loaded just before ready fell");
    high_first_a: assert property ($fell(result_ready_n_n) |-> $past(upd) == UPD_SHOW
        && $past(result_ready_n_n, 2))
        else $error("ready fell without a prior high phase");
    read_hold_a: assert property (RAW_VALID_I && reading_result && upd == UPD_IDLE
        |=> upd == UPD_IDLE && $stable(result) && ($stable(result_ready_n_n) || $past(rd_last)))
        else $error("update disturbed a result read");
    unipolar_clip_a: assert property (conv_take && UNIPOLAR_I && !FORMAT_SEL_I
        |=> !pend[DW-1])
        else $error("negative value stored in unipolar mode");
    coding_flip_a: assert property (conv_take && UNIPOLAR_I && FORMAT_SEL_I
        |=> pend[DW-1])
        else $error("offset binary sign bit wrong");
    status_mirror_a: assert property (rd_start && RD_SEL_I == SEL_STATUS
        |=> rd_byte.valid && rd_byte.data == '0 && snap[STAT_READY_BIT] == $past(result_ready_n_n))
        else $error("status bit does not mirror ready");
    byte_order_a: assert property (rd_start && RD_SEL_I == SEL_OFFSET
        |=> bytes_out($past(offset_corr)))
        else $error("read bytes out of order");
    byte_next_a: assert property (rd_byte.valid && RD_ACK_I && rd_idx == IDX_BYTE2
        |=> next_byte)
        else $error("middle byte out of order");
    cal_return_a: assert property (cal_done |-> mode == MODE_NORMAL
        && $past(in_cal))
        else $error("calibration did not return to normal");
    offset_cal_a: assert property (mode == MODE_SYS_OFFSET && RAW_VALID_I
        |=> offset_corr == DW'(signed'($past(RAW_DATA_I)) >>> OFF_SHIFT) && cal_done)
        else $error("offset calibration result not stored");
endmodule // adcrc_regs

// File: inc/adcrc_pkg.sv
// Shared constants and types for the converter result and calibration registers.
// Assumes one master clock domain; the serial front end and filter share it.
package adcrc_pkg;
    // ===========================================================
    // widths and register selects
    localparam int DW = 24;
    localparam int BW = 8;
    localparam logic [1:0] SEL_RESULT = 2'h0;
    localparam logic [1:0] SEL_OFFSET = 2'h1;
    localparam logic [1:0] SEL_FSCALE = 2'h2;
    localparam logic [1:0] SEL_STATUS = 2'h3;
    localparam int STAT_READY_BIT = 0;
    // ===========================================================
    // operating mode codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF_CAL = 3'h1;
    localparam logic [2:0] MODE_SYS_OFFSET = 3'h2;
    localparam logic [2:0] MODE_SYS_FSCALE = 3'h3;
    // ===========================================================
    // reset values and correction arithmetic
    localparam logic [23:0] OFFSET_RST = 24'h000000;
    localparam logic [23:0] FSCALE_RST = 24'h400000;
    localparam logic [24:0] FSCALE_TWICE = 25'h0800000;
    localparam int OFF_SHIFT = 1;
    localparam int FS_SHIFT = 22;
    localparam logic signed [23:0] POS_MAX = 24'sh7FFFFF;
    localparam logic signed [23:0] NEG_MIN = 24'sh800000;
    localparam logic [23:0] SIGN_FLIP = 24'h800000;
    localparam logic [1:0] IDX_BYTE2 = 2'h2;
    localparam logic [1:0] IDX_BYTE0 = 2'h0;
    // ===========================================================
    // types
    typedef enum logic [1:0] {UPD_IDLE, UPD_LOAD, UPD_SHOW} adcrc_upd_t;
    typedef struct packed {
        logic [1:0] sel;
        logic [23:0] data;
    } adcrc_wr_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } adcrc_rdbyte_t;
endpackage

// File: tb/adcrc_host_model.sv
// Host model: reads the converter registers a byte at a time and writes them a whole 24-bit word at a time.
// Assumes the bench calls its tasks; all changes follow a falling edge.
module adcrc_host_model
    import adcrc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // register port
    input wire adcrc_rdbyte_t rd_byte_i,
    output logic rd_req_o,
    output logic [1:0] rd_sel_o,
    output logic rd_ack_o,
    output logic wr_o,
    output adcrc_wr_t wr_req_o
);
    // cycles to wait before taking each byte; 0 is a prompt host
    int stall = 0;
    initial begin
        rd_req_o = 1'b0;
        rd_sel_o = 2'h0;
        rd_ack_o = 1'b0;
        wr_o = 1'b0;
        wr_req_o = '0;
    end
    task automatic write_reg(input logic [1:0] sel, input logic [23:0] data);
        @(negedge clk_i);
        wr_o = 1'b1;
        wr_req_o = '{sel: sel, data: data};
        @(negedge clk_i);
        wr_o = 1'b0;
        // released word no longer shows the old value
        wr_req_o = ~wr_req_o;
    endtask
    // read follows ready at once, well inside a data period
    task automatic read_reg(input logic [1:0] sel, output logic [23:0] val, output logic ok);
        int n;
        val = '0;
        ok = 1'b0;
        n = 0;
        @(negedge clk_i);
        rd_req_o = 1'b1;
        rd_sel_o = sel;
        @(negedge clk_i);
        rd_req_o = 1'b0;
        rd_sel_o = ~sel;
        while (rd_byte_i.valid !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        if (rd_byte_i.valid !== 1'b1) return;
        for (int i = 0; i < 3; i++) begin
            repeat (stall) @(negedge clk_i);
            val = {val[15:0], rd_byte_i.data};
            rd_ack_o = 1'b1;
            @(negedge clk_i);
            if (stall != 0 || i == 2) rd_ack_o = 1'b0;
        end
        ok = 1'b1;
    endtask
endmodule // adcrc_host_model

// File: tb/tb_adc_result_and_calibration_regs.sv
// Self-checking bench for the result and calibration registers.
// Assumes the host model and the package are compiled first.
module tb_adc_result_and_calibration_regs
    import adcrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(nm, ex, gt) \
    begin \
        samples_checked++; \
        if ((gt) !== (ex)) begin \
            errors++; \
            $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
        end \
    end
    logic clk = 1'b0, nrst_n = 1'b0, raw_valid = 1'b0, fmt = 1'b0, uni = 1'b0;
    logic mode_wr = 1'b0, rd_req, rd_ack, wr, ready_n, cal_done, ok;
    logic [23:0] raw_data = '0, v, off_exp = OFFSET_RST, fs_exp = FSCALE_RST;
    logic [2:0] mode_in = 3'h0, mode_out;
    logic [1:0] rd_sel;
    adcrc_wr_t wr_req;
    adcrc_rdbyte_t rd_byte;
    int errors = 0;
    int samples_checked = 0;
    initial forever #2.5 clk = ~clk;
    adcrc_regs u_adcrc_regs (.CLK_I(clk), .NRST_I(nrst_n), .RAW_VALID_I(raw_valid),
        .RAW_DATA_I(raw_data), .FORMAT_SEL_I(fmt), .UNIPOLAR_I(uni), .MODE_WR_I(mode_wr),
        .MODE_I(mode_in), .WR_I(wr), .WR_REQ_I(wr_req), .RD_REQ_I(rd_req),
        .RD_SEL_I(rd_sel), .RD_ACK_I(rd_ack), .RD_BYTE_O(rd_byte),
        .RESULT_READY_N_O(ready_n), .OPERATING_MODE_SEL_O(mode_out), .CAL_DONE_O(cal_done));
    adcrc_host_model u_adcrc_host_model (.clk_i(clk), .rd_byte_i(rd_byte), .rd_req_o(rd_req),
        .rd_sel_o(rd_sel), .rd_ack_o(rd_ack), .wr_o(wr), .wr_req_o(wr_req));
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // gain is fullscale over 2^22; offset counts twice
    function automatic logic [23:0] exp_result(input logic [23:0] r, input logic f, input logic u);
        longint p;
        p = ((longint'($signed(r)) - 2 * longint'($signed(off_exp))) * longint'(fs_exp)) >>> 22;
        if (p > 8388607) p = 8388607;
        if (p < -8388608) p = -8388608;
        if (u && p < 0) p = 0;
        return f ? (p[23:0] ^ 24'h800000) : p[23:0];
    endfunction
    task automatic rd_chk(input logic [1:0] sel, input logic [23:0] ex, input string nm);
        u_adcrc_host_model.read_reg(sel, v, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH %s expected bytes seen timeout", nm);
            test_done();
        end else begin
            `CHK(nm, ex, v)
        end
    endtask
    task automatic pulse_raw(input logic [23:0] r);
        @(negedge clk);
        raw_data = r;
        raw_valid = 1'b1;
        @(negedge clk);
        raw_valid = 1'b0;
        raw_data = ~r;
    endtask
    task automatic conv_chk(input logic [23:0] r, input logic f, input logic u);
        @(negedge clk);
        fmt = f;
        uni = u;
        pulse_raw(r);
        `CHK("ready up for update", 1'b1, ready_n)
        repeat (2) @(negedge clk);
        `CHK("ready down", 1'b0, ready_n)
        rd_chk(SEL_STATUS, 24'h000000, "status ready");
        rd_chk(SEL_RESULT, exp_result(r, f, u), "result");
        `CHK("ready up after read", 1'b1, ready_n)
    endtask
    task automatic cal_chk(input logic [2:0] md, input logic [23:0] r1, input logic [23:0] r2);
        @(negedge clk);
        mode_in = md;
        mode_wr = 1'b1;
        @(negedge clk);
        mode_wr = 1'b0;
        `CHK("mode held", md, mode_out)
        if (md != MODE_SYS_FSCALE) begin
            pulse_raw(r1);
            off_exp = 24'($signed(r1) >>> 1);
        end
        if (md != MODE_SYS_OFFSET) begin
            if (md == MODE_SELF_CAL) begin
                `CHK("done too early", 1'b0, cal_done)
                @(negedge clk);
            end
            pulse_raw(r2);
            fs_exp = 24'h800000 - (r2 - {off_exp[22:0], 1'b0});
        end
        `CHK("cal done", 1'b1, cal_done)
        `CHK("back to normal", MODE_NORMAL, mode_out)
        @(negedge clk);
        `CHK("done one cycle", 1'b0, cal_done)
        rd_chk(SEL_OFFSET, off_exp, "cal offset");
        rd_chk(SEL_FSCALE, fs_exp, "cal fullscale");
    endtask
    // ===========================================================
    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        nrst_n = 1'b1;
        `CHK("reset ready", 1'b1, ready_n)
        `CHK("reset mode", MODE_NORMAL, mode_out)
        rd_chk(SEL_OFFSET, OFFSET_RST, "offset reset");
        rd_chk(SEL_FSCALE, FSCALE_RST, "fullscale reset");
        rd_chk(SEL_STATUS, 24'h000001, "status idle");
        conv_chk(24'h123456, 1'b0, 1'b0);
        conv_chk(24'hF00000, 1'b1, 1'b0);
        conv_chk(24'hF00000, 1'b0, 1'b1);
        conv_chk(24'h7FFFF0, 1'b1, 1'b1);
        u_adcrc_host_model.write_reg(SEL_RESULT, 24'hABCDEF);
        rd_chk(SEL_RESULT, 24'hFFFFF0, "result read only");
        u_adcrc_host_model.stall = 2;
        u_adcrc_host_model.write_reg(SEL_OFFSET, 24'h000100);
        u_adcrc_host_model.write_reg(SEL_FSCALE, 24'h600000);
        off_exp = 24'h000100;
        fs_exp = 24'h600000;
        rd_chk(SEL_OFFSET, off_exp, "offset write");
        rd_chk(SEL_FSCALE, fs_exp, "fullscale write");
        u_adcrc_host_model.stall = 0;
        conv_chk(24'h100000, 1'b0, 1'b0);
        conv_chk(24'h700000, 1'b0, 1'b0);
        u_adcrc_host_model.write_reg(SEL_OFFSET, 24'hFFFF00);
        off_exp = 24'hFFFF00;
        conv_chk(24'h000000, 1'b1, 1'b0);
        // unread result is replaced by the next one
        pulse_raw(24'h0A0B0C);
        repeat (2) @(negedge clk);
        conv_chk(24'h010203, 1'b0, 1'b0);
        // a result arriving while the result is being read is dropped
        u_adcrc_host_model.stall = 2;
        fork
            rd_chk(SEL_RESULT, exp_result(24'h010203, 1'b0, 1'b0), "result in read");
            begin
                repeat (3) @(negedge clk);
                pulse_raw(24'h333333);
            end
        join
        u_adcrc_host_model.stall = 0;
        `CHK("ready stays up", 1'b1, ready_n)
        cal_chk(MODE_SYS_OFFSET, 24'h000200, 24'h000000);
        cal_chk(MODE_SYS_FSCALE, 24'h000000, 24'h100200);
        cal_chk(MODE_SELF_CAL, 24'hFFFE00, 24'h0FFE00);
        conv_chk(24'h200000, 1'b0, 1'b0);
        test_done();
    end
endmodule // tb_adc_result_and_calibration_regs
